// >>> logic/uci_irq.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module uci_irq
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cts_pin,
  input  wire logic        rts_pin,
  input  wire logic        xoff_match,
  input  wire logic        xon_match,
  input  wire logic        msr_delta,
  input  wire logic        msr_read,
  input  wire logic        overrun_evt,
  input  wire logic        rx_err_read,
  input  wire logic        lsr_read,
  input  wire logic        thr_empty,
  input  wire logic        rx_data_ready,
  input  wire logic        rx_timeout,
  output logic             irq_out,
  output logic             sleep_mode,
  output logic             tx_wr_strobe,
  output logic      [7:0]  tx_wr_data
);

  logic [7:0]  mask_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  ident_q;
  logic [7:0]  ident_d;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        irq_q;
  logic        sleep_q;
  logic        txwr_q;
  logic [7:0]  txdata_q;
  logic        cts_prev_q;
  logic        rts_prev_q;
  logic        thr_prev_q;
  logic        flow_q;
  logic        xoff_q;
  logic        modem_q;
  logic        line_q;
  logic        txe_q;
  logic        enh;
  logic        fifo_on;
  logic        setup;
  logic        done;
  logic        wr_done;
  logic        rd_done;
  logic        ident_sel;
  logic        ident_rd_done;
  logic        txh_wr_done;
  logic        freeze;
  logic [5:0]  src;

  // Word index of a byte address; unaligned or high addresses map to none
  function automatic logic [7:0] reg_index(input logic [31:0] a);
    if (a[1:0] != 2'b00 || a[31:10] != 22'h0)
      reg_index = 8'hff;
    else
      reg_index = a[9:2];
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    logic [7:0] i;
    i = reg_index(a);
    mapped = (i == uci_pkg::IDX_TX_HOLDING) || (i == uci_pkg::IDX_MASK) ||
             (i == uci_pkg::IDX_IDENT) || (i == uci_pkg::IDX_CTRL);
  endfunction

  assign enh     = ctrl_q[uci_pkg::CB_ENH];
  assign fifo_on = ctrl_q[uci_pkg::CB_FIFO_ON];

  assign setup     = psel && !penable;
  assign done      = psel && penable && pready_q;
  assign wr_done   = done && pwrite && !pslverr_q;
  assign rd_done   = done && !pwrite && !pslverr_q;
  assign ident_sel = reg_index(paddr) == uci_pkg::IDX_IDENT;
  assign ident_rd_done = rd_done && ident_sel;
  assign txh_wr_done   = wr_done && reg_index(paddr) == uci_pkg::IDX_TX_HOLDING;
  // Held from setup through the completing edge of an identification read
  assign freeze = psel && !pwrite && ident_sel;

  // Zero-wait access phase: ready rises in the cycle after setup
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped(paddr);
    end
  end

  // Read data captured in setup, so an ident read returns the frozen value
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      prdata_q <= 32'h0;
    else if (setup && !pwrite)
    begin
      unique case (reg_index(paddr))
        uci_pkg::IDX_MASK:  prdata_q <= {24'h0, mask_q};
        uci_pkg::IDX_IDENT: prdata_q <= {24'h0, ident_q};
        uci_pkg::IDX_CTRL:  prdata_q <= {24'h0, ctrl_q};
        default:            prdata_q <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      mask_q <= uci_pkg::MASK_RESET;  // see [RQ10]
    else if (wr_done && reg_index(paddr) == uci_pkg::IDX_MASK)
      mask_q <= pwdata[7:0];  // see [RQ10]
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= uci_pkg::CTRL_RESET;
    else if (wr_done && reg_index(paddr) == uci_pkg::IDX_CTRL)
      ctrl_q <= pwdata[7:0] &
                (8'h01 << uci_pkg::CB_FIFO_ON | 8'h01 << uci_pkg::CB_ENH);
  end

  // Holding register write is passed out as a one-cycle strobe with data
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txwr_q   <= 1'b0;
      txdata_q <= 8'h00;
    end
    else
    begin
      txwr_q <= txh_wr_done;
      if (txh_wr_done)
        txdata_q <= pwdata[7:0];
    end
  end

  // Previous values start high so a pin high at reset gives no edge
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cts_prev_q <= 1'b1;
      rts_prev_q <= 1'b1;
      thr_prev_q <= 1'b1;
    end
    else
    begin
      cts_prev_q <= cts_pin;
      rts_prev_q <= rts_pin;
      thr_prev_q <= thr_empty;
    end
  end

  // Sticky status flags run whatever the mask holds; set beats clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      flow_q <= 1'b0;
    else if ((cts_pin && !cts_prev_q) || (rts_pin && !rts_prev_q))
      flow_q <= 1'b1;  // see [RQ18]
    else if (ident_rd_done || msr_read)
      flow_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      xoff_q <= 1'b0;
    else if (xoff_match)
      xoff_q <= 1'b1;
    else if (ident_rd_done || xon_match)
      xoff_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      modem_q <= 1'b0;
    else if (msr_delta)
      modem_q <= 1'b1;
    else if (msr_read)
      modem_q <= 1'b0;
  end

  // Overrun flags on arrival; other errors only once their byte is read out
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      line_q <= 1'b0;
    else if (overrun_evt || rx_err_read)
      line_q <= 1'b1;  // see [RQ7]
    else if (lsr_read)
      line_q <= 1'b0;
  end

  // Empty interrupt re-arms on each rise of the empty level
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      txe_q <= 1'b0;
    else if (thr_empty && !thr_prev_q)
      txe_q <= 1'b1;
    else if (ident_rd_done || txh_wr_done || !thr_empty)
      txe_q <= 1'b0;  // see [RQ20]
  end

  // Priority encoder, highest first
  always_comb
  begin
    src = uci_pkg::SRC_NONE;  // see [RQ17]
    if (mask_q[uci_pkg::MB_LINE] && line_q)
      src = uci_pkg::SRC_LINE;  // see [RQ6]
    else if (mask_q[uci_pkg::MB_RXAV] && fifo_on && rx_timeout)
      src = uci_pkg::SRC_TIMEOUT;  // see [RQ9]
    else if (mask_q[uci_pkg::MB_RXAV] && rx_data_ready)
      src = uci_pkg::SRC_RXRDY;  // see [RQ9]
    else if (mask_q[uci_pkg::MB_TXE] && txe_q)
      src = uci_pkg::SRC_TXE;  // see [RQ8]
    else if (mask_q[uci_pkg::MB_MDM] && modem_q)
      src = uci_pkg::SRC_MODEM;  // see [RQ5]
    else if (enh && mask_q[uci_pkg::MB_XOFF] && xoff_q)
      src = uci_pkg::SRC_XOFF;  // see [RQ3] [RQ15]
    else if (enh && flow_q &&
             ((mask_q[uci_pkg::MB_CTS] && cts_pin) ||
              (mask_q[uci_pkg::MB_RTS] && rts_pin)))
      src = uci_pkg::SRC_FLOW;  // see [RQ1] [RQ2] [RQ14]
  end
  // Limitation: the flow flag is shared, so the pin level picks the enable

  always_comb
  begin
    ident_d = {fifo_on ? uci_pkg::FIFO_FLAGS_ON : uci_pkg::FIFO_FLAGS_OFF,
               src};  // see [RQ13] [RQ19] [RQ11] [RQ16] [RQ18]
  end

  // Ident and interrupt output update together so they never disagree
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ident_q <= uci_pkg::IDENT_RESET;
      irq_q   <= 1'b0;
    end
    else if (!freeze)
    begin
      ident_q <= ident_d;  // see [RQ12]
      irq_q   <= !ident_d[0];  // see [RQ21]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sleep_q <= 1'b0;
    else
      sleep_q <= enh && mask_q[uci_pkg::MB_SLEEP];  // see [RQ4]
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign irq_out      = irq_q;
  assign sleep_mode   = sleep_q;
  assign tx_wr_strobe = txwr_q;
  assign tx_wr_data   = txdata_q;

endmodule

// >>> logic/uci_pkg.sv
// Summary of operation
// [RQ1] Mask bit 7 lets a CTS rising edge interrupt, only with enhanced enable set
// [RQ2] Mask bit 6 lets an RTS rising edge interrupt, only with enhanced enable set
// [RQ3] Mask bit 5 lets a received Xoff interrupt, only with enhanced enable set
// [RQ4] Mask bit 4 puts the channel to sleep, only with enhanced enable set
// [RQ5] Mask bit 3 lets modem status changes interrupt; clear bit blocks them
// [RQ6] Mask bit 2 raises line status interrupt when break, framing, parity or overrun
// [RQ7] Overrun flags on arrival; break, framing, parity flag when read out of FIFO
// [RQ8] Mask bit 1 raises interrupt while transmit holding register is empty
// [RQ9] Mask bit 0 enables receive data available and FIFO time-out interrupts
// [RQ10] All eight mask bits read and write, reset to zero
// [RQ11] Pending conditions ranked in seven levels, highest shown in identification
// [RQ12] Identification frozen during its read; new events latched, shown afterwards; code: flow, Xoff and empty flags set during the read clear at its end
// [RQ13] Identification bits 7:6 read 11 with FIFOs on, 00 when off
// [RQ14] Identification bit 5 shows a CTS or RTS rising edge interrupt
// [RQ15] Identification bit 4 shows an Xoff or special character match
// [RQ16] Identification bits 3:1 carry the source code, reset 000
// [RQ17] Identification bit 0 is low while an interrupt is pending, reset 1
// [RQ18] Masked sources neither show nor interrupt; status flags keep working; code: the shared flow flag lets a masked edge show via the other pin
// [RQ19] Codes by priority: 06, 0c, 04, 02, 00, 10, 20; none 01
// [RQ20] Transmit empty interrupt clears on identification read or holding write
// [RQ21] Interrupt output asserted exactly while identification bit 0 is low
package uci_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_TX_HOLDING = 8'h00;
  localparam logic [7:0] IDX_MASK       = 8'h01;
  localparam logic [7:0] IDX_IDENT      = 8'h02;
  localparam logic [7:0] IDX_CTRL       = 8'h10;

  localparam logic [7:0] MASK_RESET  = 8'h00;
  localparam logic [7:0] IDENT_RESET = 8'h01;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // Mask register bit positions
  localparam int MB_CTS   = 7;
  localparam int MB_RTS   = 6;
  localparam int MB_XOFF  = 5;
  localparam int MB_SLEEP = 4;
  localparam int MB_MDM   = 3;
  localparam int MB_LINE  = 2;
  localparam int MB_TXE   = 1;
  localparam int MB_RXAV  = 0;

  // Control register bit positions
  localparam int CB_FIFO_ON = 0;
  localparam int CB_ENH     = 4;

  // Identification codes, bits 5:0
  localparam logic [5:0] SRC_LINE    = 6'h06;
  localparam logic [5:0] SRC_TIMEOUT = 6'h0c;
  localparam logic [5:0] SRC_RXRDY   = 6'h04;
  localparam logic [5:0] SRC_TXE     = 6'h02;
  localparam logic [5:0] SRC_MODEM   = 6'h00;
  localparam logic [5:0] SRC_XOFF    = 6'h10;
  localparam logic [5:0] SRC_FLOW    = 6'h20;
  localparam logic [5:0] SRC_NONE    = 6'h01;

  localparam logic [1:0] FIFO_FLAGS_ON  = 2'b11;
  localparam logic [1:0] FIFO_FLAGS_OFF = 2'b00;

endpackage

// >>> test/uart_channel_irq_enable_ident_tb.sv
`timescale 1ns/1ps
module uart_channel_irq_enable_ident_tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic        cts_pin = 1'b0, rts_pin = 1'b0, thr_empty = 1'b0;
  logic        rx_data_ready = 1'b0, rx_timeout = 1'b0;
  logic [6:0]  pls = 7'h00;
  logic        irq_out, sleep_mode, tx_wr_strobe;
  logic [7:0]  tx_wr_data;
  int          failures = 0;
  int          total_checks = 0;

  always #5 clk_sys = ~clk_sys;

  uci_host_model host_u (.clk_sys, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready);
  uci_irq dut_u (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cts_pin, .rts_pin,
    .xoff_match(pls[0]), .xon_match(pls[1]), .msr_delta(pls[2]),
    .msr_read(pls[3]), .overrun_evt(pls[4]), .rx_err_read(pls[5]),
    .lsr_read(pls[6]), .thr_empty, .rx_data_ready, .rx_timeout, .irq_out,
    .sleep_mode, .tx_wr_strobe, .tx_wr_data);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [31:0] q);
    logic to;
    host_u.xfer(w, {24'h0, a}, {24'h0, d}, q, to);
    if (to)
    begin
      failures++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, {24'h0, x});
  endtask

  // Leaves room for the two-edge event latency before the read
  task automatic src_chk(input logic [7:0] x);
    repeat (3) @(posedge clk_sys);
    rd_chk(8'h08, x);
  endtask

  task automatic fchk(ref logic s, input logic x);
    @(negedge clk_sys);
    check({31'h0, s}, {31'h0, x});
    @(posedge clk_sys);
  endtask

  task automatic pulse(input int i);
    pls[i] <= 1'b1;
    @(posedge clk_sys);
    pls[i] <= 1'b0;
  endtask

  task automatic t_regs;
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h08, 8'h01);
    fchk(irq_out, 1'b0);
    wr(8'h04, 8'hff);
    rd_chk(8'h04, 8'hff);
    fchk(sleep_mode, 1'b0);
    wr(8'h40, 8'h11);
    fchk(sleep_mode, 1'b1);
    wr(8'h04, 8'hef);
    fchk(sleep_mode, 1'b0);
    $display("register test done");
  endtask

  task automatic t_tx;
    thr_empty <= 1'b1;
    src_chk(8'hc2);
    src_chk(8'hc1);
    thr_empty <= 1'b0;
    @(posedge clk_sys);
    thr_empty <= 1'b1;
    wr(8'h00, 8'h5a);
    check({24'h0, tx_wr_data}, 32'h0000005a);
    src_chk(8'hc1);
    thr_empty <= 1'b0;
    $display("transmit test done");
  endtask

  task automatic t_sources;
    pulse(2);
    src_chk(8'hc0);
    fchk(irq_out, 1'b1);
    pulse(3);
    src_chk(8'hc1);
    pulse(0);
    src_chk(8'hd0);
    pulse(0);
    pulse(1);
    src_chk(8'hc1);
    cts_pin <= 1'b1;
    src_chk(8'he0);
    cts_pin <= 1'b0;
    rts_pin <= 1'b1;
    src_chk(8'he0);
    rts_pin <= 1'b0;
    rx_data_ready <= 1'b1;
    rx_timeout <= 1'b1;
    pulse(4);
    src_chk(8'hc6);
    pulse(6);
    src_chk(8'hcc);
    rx_timeout <= 1'b0;
    src_chk(8'hc4);
    rx_data_ready <= 1'b0;
    pulse(5);
    src_chk(8'hc6);
    pulse(6);
    src_chk(8'hc1);
    $display("source test done");
  endtask

  task automatic t_masked;
    wr(8'h04, 8'h00);
    pulse(2);
    src_chk(8'hc1);
    fchk(irq_out, 1'b0);
    wr(8'h04, 8'h08);
    src_chk(8'hc0);
    pulse(3);
    wr(8'h40, 8'h00);
    src_chk(8'h01);
    $display("mask test done");
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_tx();
    t_sources();
    t_masked();
    end_of_test();
  end
endmodule

// >>> test/uci_host_model.sv
`timescale 1ns/1ps
module uci_host_model
(
  input  wire logic        clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
  end

  // Idle edge at the end keeps two transfers from touching psel at once
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic to);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q  = prdata;
    to = pready !== 1'b1;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule

// >>> test/uci_irq_assertions.sv
`timescale 1ns/1ps
module uci_irq_checker
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_out,
  input wire logic        tx_wr_strobe,
  input wire logic [7:0]  tx_wr_data
);
  logic setup;
  logic id_rd;
  logic id_done;
  assign setup   = psel && !penable;
  assign id_rd   = !pwrite && paddr == 32'h8;
  assign id_done = pready && id_rd && !pslverr;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_ready_after_setup: assert property (
    setup |=> pready && penable) else $error("no ready after setup");
  a_read_frozen: assert property (
    setup && id_rd |=> $stable(irq_out) [*2]) else $error("irq moved in read");
  a_irq_vs_ident: assert property (
    id_done |-> prdata[0] == !irq_out) else $error("irq and ident differ");
  a_idle_code: assert property (
    id_done && prdata[0] |-> prdata[5:1] == 5'h00) else $error("idle code");
  a_pending_code: assert property (
    id_done && !prdata[0] |-> prdata[5:0] inside {6'h06, 6'h0c, 6'h04,
    6'h02, 6'h00, 6'h10, 6'h20}) else $error("bad source code");
  a_fifo_flags: assert property (
    id_done |-> prdata[7:6] inside {2'b00, 2'b11}) else $error("fifo flags");
  a_upper_zero: assert property (
    pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
  a_holding_strobe: assert property (
    pready && penable && pwrite && paddr == 32'h0
    |=> tx_wr_strobe && tx_wr_data == $past(pwdata[7:0]))
    else $error("holding write lost");
  c_pending: cover property (id_done && !prdata[0]);
  c_idle: cover property (id_done && prdata[0]);
  c_strobe: cover property (tx_wr_strobe);
endmodule
bind uci_irq uci_irq_checker chk_u (.clk_sys, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_out,
  .tx_wr_strobe, .tx_wr_data);
